// *** verilog/csb_cfg.svh ***
`ifndef CSB_CFG_SVH
`define CSB_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define CSB_CLK_NS 8
`define CSB_MINOR_NS 40
`define CSB_BANK_CYCLE_NS 1200
`define CSB_MINOR_CLKS ((`CSB_MINOR_NS + `CSB_CLK_NS - 1) / `CSB_CLK_NS)
`define CSB_BANK_MINORS (`CSB_BANK_CYCLE_NS / `CSB_MINOR_NS)
`define CSB_READ_LAT 5
`define CSB_WR_LAT 1
`define CSB_WE_HI_LAT 3
`define CSB_QUARTERS 4

// ****************************************
// Geometry
// ****************************************
`define CSB_REQ_LINES 64
`define CSB_BANKS_PER_SEC 4
`define CSB_ADDR_W 11
`define CSB_WORDS 2048
`define CSB_HALF_W 32
`define CSB_LANES 4
`define CSB_DATA_W 128
`define CSB_QTR_W 132
`define CSB_SWORD_W 528
`define CSB_HALVES 16
`define CSB_FIFO_DEPTH 8

`endif

// *** verilog/csb_pkg.sv ***
package csb_pkg;

  typedef enum logic [1:0] {
    CSB_IDLE  = 2'b00,
    CSB_RUN   = 2'b01,
    CSB_PAUSE = 2'b10,
    CSB_WRUN  = 2'b11
  } csb_phase_type;

endpackage

// *** verilog/csb_if.sv ***
`timescale 1ns/10ps
`include "csb_cfg.svh"
interface csb_if;
  logic tick;
  logic [`CSB_REQ_LINES-1:0] req;
  logic [`CSB_ADDR_W-1:0] addr;
  logic [1:0] qcode;
  logic split;
  logic clr_dr;
  logic mclr;
  logic [`CSB_DATA_W-1:0] wd;
  logic [`CSB_LANES-1:0] wp;
  logic [7:0] we;
  logic rd_valid;
  logic [`CSB_DATA_W-1:0] rd;
  logic [`CSB_LANES-1:0] rp;

  modport ctrl (
    output tick, req, addr, qcode, split, clr_dr, mclr, wd, wp, we,
    input rd_valid, rd, rp
  );
  modport bank (
    input tick, req, addr, qcode, split, clr_dr, mclr, wd, wp, we,
    output rd_valid, rd, rp
  );
endinterface

// *** verilog/csb_bank_end.sv ***
`timescale 1ns/10ps
// ****************************************
// ****************************************
`include "csb_cfg.svh"
module csb_bank_end #(
  parameter int SECTION = 0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  csb_if.bank link
);
  localparam int NB = `CSB_BANKS_PER_SEC;
  localparam int SW = `CSB_SWORD_W;
  localparam int QW = `CSB_QTR_W;
  localparam int HW = `CSB_HALF_W + 1;

  // ****************************************
  // Storage and bank state
  // ****************************************
  logic [SW-1:0] mem [0:NB*`CSB_WORDS-1];
  csb_pkg::csb_phase_type phase [NB];
  csb_pkg::csb_phase_type next_phase [NB];
  logic [4:0] cnt [NB];
  logic [4:0] next_cnt [NB];
  logic [`CSB_ADDR_W-1:0] addr [NB];
  logic [`CSB_ADDR_W-1:0] next_addr [NB];
  logic [1:0] qcode [NB];
  logic [1:0] next_qcode [NB];
  logic split [NB];
  logic next_split [NB];
  logic [`CSB_HALVES-1:0] en [NB];
  logic [`CSB_HALVES-1:0] next_en [NB];
  logic [SW-1:0] dreg [NB];
  logic [SW-1:0] next_dreg [NB];
  logic [QW-1:0] wbuf [NB][`CSB_QUARTERS];
  logic [QW-1:0] next_wbuf [NB][`CSB_QUARTERS];
  logic rd_valid;
  logic next_rd_valid;
  logic [`CSB_DATA_W-1:0] rd;
  logic [`CSB_DATA_W-1:0] next_rd;
  logic [`CSB_LANES-1:0] rp;
  logic [`CSB_LANES-1:0] next_rp;
  logic mem_we;
  logic [12:0] mem_idx;
  logic [SW-1:0] mem_din;

  // ****************************************
  // Helpers
  // ****************************************
  // Returns {defined, quarter} for a transfer step
  function automatic logic [2:0] qsel(input logic [1:0] code, input logic [1:0] step);
    logic [2:0] r;
    r = {1'b1, step};
    unique case (code)
      2'b00: r = {1'b1, step};
      2'b01: r = {step != 2'd3, step + 2'd1};
      2'b10: r = {step < 2'd2, step + 2'd2};
      2'b11: r = {1'b1, 2'd3 - step};
    endcase
    return r;
  endfunction

  // Trunk lanes to a stored quarter, lane j as {parity, data}
  function automatic logic [QW-1:0] to_qtr(input logic [`CSB_DATA_W-1:0] d,
                                            input logic [`CSB_LANES-1:0] p);
    logic [QW-1:0] q;
    q = '0;
    for (int j = 0; j < `CSB_LANES; j++) begin
      q[j*HW +: HW] = {p[j], d[j*`CSB_HALF_W +: `CSB_HALF_W]};
    end
    return q;
  endfunction

  // ****************************************
  // Bank sequencing
  // ****************************************
  always_comb begin
    logic line;
    logic [2:0] sel;
    logic [1:0] step;
    logic [SW-1:0] wflat;
    logic [QW-1:0] qv;
    line = 1'b0;
    sel = '0;
    step = '0;
    wflat = '0;
    qv = '0;
    next_phase = phase;
    next_cnt = cnt;
    next_addr = addr;
    next_qcode = qcode;
    next_split = split;
    next_en = en;
    next_dreg = dreg;
    next_wbuf = wbuf;
    next_rd_valid = link.tick ? 1'b0 : rd_valid;
    next_rd = link.tick ? '0 : rd;
    next_rp = link.tick ? '0 : rp;
    mem_we = 1'b0;
    mem_idx = '0;
    mem_din = '0;
    if (link.tick) begin
      for (int b = 0; b < NB; b++) begin
        line = link.req[SECTION*NB + b];
        unique case (phase[b])
          csb_pkg::CSB_IDLE: begin
            if (line) begin
              next_phase[b] = csb_pkg::CSB_RUN;
              next_cnt[b] = 5'd1;
              next_addr[b] = link.addr;
              next_qcode[b] = link.qcode;
              next_split[b] = link.split;
              next_en[b] = '0;
              next_dreg[b] = mem[{2'(b), link.addr}];
            end
          end
          csb_pkg::CSB_PAUSE: begin
            if (link.clr_dr) begin
              next_dreg[b] = '0;
            end
            if (line) begin
              next_phase[b] = csb_pkg::CSB_WRUN;
              next_cnt[b] = 5'd1;
              next_en[b] = '0;
            end
          end
          csb_pkg::CSB_RUN, csb_pkg::CSB_WRUN: begin
            next_cnt[b] = cnt[b] + 5'd1;
            if (cnt[b] == 5'(`CSB_WR_LAT)) begin
              next_en[b][7:0] = link.we;
            end
            if (cnt[b] == 5'(`CSB_WE_HI_LAT)) begin
              next_en[b][15:8] = link.we;
            end
            if (cnt[b] >= 5'(`CSB_WR_LAT) && cnt[b] < 5'(`CSB_WR_LAT + `CSB_QUARTERS)) begin
              step = 2'(cnt[b] - 5'(`CSB_WR_LAT));
              sel = qsel(qcode[b], step);
              next_wbuf[b][sel[1:0]] = to_qtr(link.wd, link.wp);
            end
            if (phase[b] == csb_pkg::CSB_RUN && en[b] == '0 &&
                cnt[b] >= 5'(`CSB_READ_LAT - 1) &&
                cnt[b] < 5'(`CSB_READ_LAT - 1 + `CSB_QUARTERS)) begin
              step = 2'(cnt[b] - 5'(`CSB_READ_LAT - 1));
              sel = qsel(qcode[b], step);
              if (sel[2]) begin
                qv = dreg[b][sel[1:0]*QW +: QW];
                next_rd_valid = 1'b1;
                for (int j = 0; j < `CSB_LANES; j++) begin
                  next_rd[j*`CSB_HALF_W +: `CSB_HALF_W] = qv[j*HW +: `CSB_HALF_W];
                  next_rp[j] = qv[j*HW + `CSB_HALF_W];
                end
              end
            end
            if (cnt[b] == 5'(`CSB_WR_LAT + `CSB_QUARTERS) && en[b] != '0) begin
              wflat = {wbuf[b][3], wbuf[b][2], wbuf[b][1], wbuf[b][0]};
              for (int h = 0; h < `CSB_HALVES; h++) begin
                if (en[b][h]) begin
                  next_dreg[b][h*HW +: HW] = wflat[h*HW +: HW];
                end
              end
              mem_we = 1'b1;
              mem_idx = {2'(b), addr[b]};
              mem_din = next_dreg[b];
              if (phase[b] == csb_pkg::CSB_WRUN) begin
                next_phase[b] = csb_pkg::CSB_IDLE;
              end
            end
            if (phase[b] == csb_pkg::CSB_RUN && split[b] &&
                cnt[b] == 5'(`CSB_READ_LAT - 1 + `CSB_QUARTERS)) begin
              next_phase[b] = csb_pkg::CSB_PAUSE;
            end
            if (cnt[b] == 5'(`CSB_BANK_MINORS)) begin
              next_phase[b] = csb_pkg::CSB_IDLE;
            end
          end
        endcase
        if (link.mclr) begin
          next_phase[b] = csb_pkg::CSB_IDLE;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int b = 0; b < NB; b++) begin
        phase[b] <= csb_pkg::CSB_IDLE;
        cnt[b] <= '0;
        addr[b] <= '0;
        qcode[b] <= '0;
        split[b] <= 1'b0;
        en[b] <= '0;
        dreg[b] <= '0;
        for (int q = 0; q < `CSB_QUARTERS; q++) begin
          wbuf[b][q] <= '0;
        end
      end
      rd_valid <= 1'b0;
      rd <= '0;
      rp <= '0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      addr <= next_addr;
      qcode <= next_qcode;
      split <= next_split;
      en <= next_en;
      dreg <= next_dreg;
      wbuf <= next_wbuf;
      rd_valid <= next_rd_valid;
      rd <= next_rd;
      rp <= next_rp;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_din;
    end
  end

  assign link.rd_valid = rd_valid;
  assign link.rd = rd;
  assign link.rp = rp;
endmodule

// *** verilog/csb_ctrl_end.sv ***
`timescale 1ns/10ps
`include "csb_cfg.svh"
// ****************************************
// Write data FIFO
// ****************************************
module csb_fifo #(
  parameter int WIDTH = `CSB_DATA_W,
  parameter int DEPTH = `CSB_FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_mem [DEPTH];
  logic [AW-1:0] rp, next_rp, wp, next_wp;
  logic [AW:0] cnt, next_cnt;
  logic room, next_room;
  logic push, pop;

  always_comb begin
    push = in_valid_i && room;
    pop = out_ready_i && cnt != '0;
    next_wp = push ? AW'(wp + 1'b1) : wp;
    next_rp = pop ? AW'(rp + 1'b1) : rp;
    next_cnt = (AW+1)'(cnt + (AW+1)'(push) - (AW+1)'(pop));
    next_room = next_cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rp <= '0;
      wp <= '0;
      cnt <= '0;
      room <= 1'b0;
    end else begin
      rp <= next_rp;
      wp <= next_wp;
      cnt <= next_cnt;
      room <= next_room;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      buf_mem[wp] <= in_data_i;
    end
  end

  assign in_ready_o = room;
  assign out_valid_o = cnt != '0;
  assign out_data_o = buf_mem[rp];
  assign count_o = cnt;
endmodule

// ****************************************
// Memory access controller end
// ****************************************
module csb_ctrl_end (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  csb_if.ctrl link,
  input wire logic req_valid_i,
  input wire logic [5:0] req_bank_i,
  input wire logic [`CSB_ADDR_W-1:0] req_addr_i,
  input wire logic [1:0] req_qcode_i,
  input wire logic [`CSB_HALVES-1:0] req_en_i,
  input wire logic req_split_i,
  input wire logic req_resume_i,
  output logic req_taken_o,
  input wire logic wd_valid_i,
  input wire logic [`CSB_DATA_W-1:0] wd_data_i,
  output logic wd_ready_o,
  input wire logic clr_dr_i,
  input wire logic mclr_i,
  output logic rd_valid_o,
  output logic [`CSB_DATA_W-1:0] rd_data_o,
  output logic [`CSB_LANES-1:0] rd_par_err_o
);
  localparam int NL = `CSB_REQ_LINES;
  logic [2:0] div, next_div;
  logic tick, next_tick;
  logic [2:0] step, next_step;
  logic cur_wr, next_cur_wr;
  logic [`CSB_HALVES-1:0] en_hold, next_en_hold;
  logic [4:0] busy [NL];
  logic [4:0] next_busy [NL];
  logic [NL-1:0] req, next_req;
  logic [`CSB_ADDR_W-1:0] addr, next_addr;
  logic [1:0] qcode, next_qcode;
  logic split, next_split, clr, next_clr, mclr, next_mclr;
  logic [`CSB_DATA_W-1:0] wd, next_wd;
  logic [`CSB_LANES-1:0] wp, next_wp;
  logic [7:0] we, next_we;
  logic taken, next_taken;
  logic rd_valid, next_rd_valid;
  logic [`CSB_DATA_W-1:0] rd_data, next_rd_data;
  logic [`CSB_LANES-1:0] rd_err, next_rd_err;
  logic start, take, pop, f_valid;
  logic [`CSB_DATA_W-1:0] f_data;
  logic [3:0] f_count;

  csb_fifo #(.WIDTH(`CSB_DATA_W), .DEPTH(`CSB_FIFO_DEPTH)) csb_fifo_i (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(wd_valid_i),
    .in_ready_o(wd_ready_o),
    .in_data_i(wd_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(pop),
    .out_data_o(f_data),
    .count_o(f_count)
  );

  always_comb begin
    start = div == 3'(`CSB_MINOR_CLKS - 1);
    next_div = start ? 3'd0 : 3'(div + 3'd1);
    next_tick = start;
    take = start && req_valid_i && (step == 3'd0 || step == 3'd4) &&
           (busy[req_bank_i] == 5'd0 || req_resume_i) &&
           (req_en_i == '0 || f_count >= 4'(`CSB_QUARTERS));
    pop = start && cur_wr && step != 3'd0 && f_valid;
    next_step = step;
    next_cur_wr = cur_wr;
    next_en_hold = en_hold;
    next_busy = busy;
    next_req = req;
    next_addr = addr;
    next_qcode = qcode;
    next_split = split;
    next_clr = clr;
    next_mclr = mclr;
    next_wd = wd;
    next_wp = wp;
    next_we = we;
    next_taken = 1'b0;
    if (start) begin
      next_req = '0;
      next_we = '0;
      next_wd = '0;
      next_wp = '0;
      next_clr = clr_dr_i;
      next_mclr = mclr_i;
      for (int i = 0; i < NL; i++) begin
        if (busy[i] != 5'd0) begin
          next_busy[i] = busy[i] - 5'd1;
        end
      end
      next_step = (step == 3'd0 || step == 3'd4) ? 3'd0 : step + 3'd1;
      if (cur_wr && step != 3'd0) begin
        next_wd = f_data;
        for (int j = 0; j < `CSB_LANES; j++) begin
          next_wp[j] = ~^f_data[j*`CSB_HALF_W +: `CSB_HALF_W];
        end
        if (step == 3'(`CSB_WR_LAT)) begin
          next_we = en_hold[7:0];
        end
        if (step == 3'(`CSB_WE_HI_LAT)) begin
          next_we = en_hold[15:8];
        end
      end
      if (take) begin
        next_req[req_bank_i] = 1'b1;
        next_addr = req_addr_i;
        next_qcode = req_qcode_i;
        next_split = req_split_i;
        next_cur_wr = req_en_i != '0;
        next_en_hold = req_en_i;
        next_busy[req_bank_i] = 5'(`CSB_BANK_MINORS);
        next_step = 3'd1;
        next_taken = 1'b1;
      end
    end
    next_rd_valid = tick && link.rd_valid;
    next_rd_data = link.rd;
    next_rd_err = '0;
    for (int j = 0; j < `CSB_LANES; j++) begin
      next_rd_err[j] = next_rd_valid &&
                       !(^{link.rp[j], link.rd[j*`CSB_HALF_W +: `CSB_HALF_W]});
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div <= '0;
      tick <= 1'b0;
      step <= '0;
      cur_wr <= 1'b0;
      en_hold <= '0;
      for (int i = 0; i < NL; i++) begin
        busy[i] <= '0;
      end
      req <= '0;
      addr <= '0;
      qcode <= '0;
      split <= 1'b0;
      clr <= 1'b0;
      mclr <= 1'b0;
      wd <= '0;
      wp <= '0;
      we <= '0;
      taken <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_err <= '0;
    end else begin
      div <= next_div;
      tick <= next_tick;
      step <= next_step;
      cur_wr <= next_cur_wr;
      en_hold <= next_en_hold;
      busy <= next_busy;
      req <= next_req;
      addr <= next_addr;
      qcode <= next_qcode;
      split <= next_split;
      clr <= next_clr;
      mclr <= next_mclr;
      wd <= next_wd;
      wp <= next_wp;
      we <= next_we;
      taken <= next_taken;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      rd_err <= next_rd_err;
    end
  end

  assign link.tick = tick;
  assign link.req = req;
  assign link.addr = addr;
  assign link.qcode = qcode;
  assign link.split = split;
  assign link.clr_dr = clr;
  assign link.mclr = mclr;
  assign link.wd = wd;
  assign link.wp = wp;
  assign link.we = we;
  assign req_taken_o = taken;
  assign rd_valid_o = rd_valid;
  assign rd_data_o = rd_data;
  assign rd_par_err_o = rd_err;
endmodule

// *** testbench/csb_chk_sva.sv ***
`timescale 1ns/10ps
`include "csb_cfg.svh"
module csb_chk_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic tick,
  input wire logic [`CSB_REQ_LINES-1:0] req,
  input wire logic [`CSB_ADDR_W-1:0] addr,
  input wire logic [1:0] qcode,
  input wire logic split,
  input wire logic [7:0] we,
  input wire logic [`CSB_DATA_W-1:0] wd,
  input wire logic [`CSB_LANES-1:0] wp,
  input wire logic rd_valid
);
  // ****************************************
  // Link timing, one-hot request and write parity checks
  // ****************************************
  logic req_any;
  logic bank_hit;
  assign req_any = |req;
  assign bank_hit = tick && (|req[3:0]);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_minor;
    !tick[*4] ##1 tick;
  endsequence
  sequence s_no_req;
    !req_any[*5];
  endsequence

  property p_tick_period;
    tick |=> s_minor;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

  property p_req_onehot;
    req_any |-> $onehot(req);
  endproperty
  a_req_onehot: assert property (p_req_onehot) else $error("more than one request");

  property p_req_width;
    $rose(req_any) |-> req_any[*5] ##1 !req_any;
  endproperty
  a_req_width: assert property (p_req_width) else $error("request not one minor");

  property p_link_sync;
    $changed({req, addr, qcode, split, we, wd, wp}) |-> $rose(tick);
  endproperty
  a_link_sync: assert property (p_link_sync) else $error("link changed mid minor");

  property p_rd_lat;
    $rose(rd_valid) |-> $past(bank_hit, 21);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data latency wrong");

  property p_rd_quarters;
    $rose(rd_valid) |-> rd_valid[*8];
  endproperty
  a_rd_quarters: assert property (p_rd_quarters) else $error("read burst too short");

  property p_we_slot;
    tick && (we != 8'h00) |-> $past(req_any, 5) || $past(req_any, 15);
  endproperty
  a_we_slot: assert property (p_we_slot) else $error("enables out of slot");

  property p_wp_odd;
    tick && (we != 8'h00) |-> (^{wd[31:0], wp[0]}) && (^{wd[63:32], wp[1]})
      && (^{wd[95:64], wp[2]}) && (^{wd[127:96], wp[3]});
  endproperty
  a_wp_odd: assert property (p_wp_odd) else $error("write parity not odd");

  property p_req_gap;
    tick && req_any |=> ##4 s_no_req ##1 s_no_req ##1 s_no_req;
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("requests too close");
endmodule

// *** testbench/core_storage_bank_interface_bench.sv ***
`timescale 1ns/10ps
`include "csb_cfg.svh"
`define CSB_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module core_storage_bank_interface_bench;
  // ****************************************
  // Stimulus and scoreboard
  // ****************************************
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic [5:0] req_bank_i = 6'h00;
  logic [`CSB_ADDR_W-1:0] req_addr_i = 11'h000;
  logic [1:0] req_qcode_i = 2'h0;
  logic [`CSB_HALVES-1:0] req_en_i = 16'h0000;
  logic req_split_i = 1'b0;
  logic req_resume_i = 1'b0;
  logic req_taken_o;
  logic wd_valid_i = 1'b0;
  logic [`CSB_DATA_W-1:0] wd_data_i = 128'h0;
  logic wd_ready_o;
  logic clr_dr_i = 1'b0;
  logic mclr_i = 1'b0;
  logic rd_valid_o;
  logic [`CSB_DATA_W-1:0] rd_data_o;
  logic [`CSB_LANES-1:0] rd_par_err_o;
  logic [127:0] mon_exp;
  logic [3:0] mon_par;
  logic [3:0] ep_q [$];
  logic [127:0] mdl [int];
  logic [127:0] exp_q [$];
  logic [127:0] wq [$];
  int n_mismatch = 0;
  int tests_run = 0;

  csb_if link();
  csb_ctrl_end csb_ctrl_end_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
    .req_valid_i(req_valid_i), .req_bank_i(req_bank_i), .req_addr_i(req_addr_i),
    .req_qcode_i(req_qcode_i), .req_en_i(req_en_i), .req_split_i(req_split_i),
    .req_resume_i(req_resume_i), .req_taken_o(req_taken_o), .wd_valid_i(wd_valid_i),
    .wd_data_i(wd_data_i), .wd_ready_o(wd_ready_o), .clr_dr_i(clr_dr_i), .mclr_i(mclr_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_par_err_o(rd_par_err_o));
  csb_bank_end #(.SECTION(0)) csb_bank_end_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link(link));
  csb_chk_sva csb_chk_sva_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tick(link.tick),
    .req(link.req), .addr(link.addr), .qcode(link.qcode), .split(link.split),
    .we(link.we), .wd(link.wd), .wp(link.wp), .rd_valid(link.rd_valid));

  always #4 sys_clk_i = ~sys_clk_i;

  function automatic int qord(input logic [1:0] c, input int k);
    case (c)
      2'b00: return k;
      2'b11: return 3 - k;
      2'b01: return k + 1;
      default: return k + 2;
    endcase
  endfunction

  function automatic int key(input logic [5:0] b, input logic [10:0] a, input int q);
    return int'(b) * 8192 + int'(a) * 4 + q;
  endfunction

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic give_up();
    n_mismatch++;
    test_done();
  endtask

  task automatic fill(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      wd_valid_i = 1'b1;
      wd_data_i = {$urandom, $urandom, $urandom, $urandom};
      wq.push_back(wd_data_i);
      while (wd_ready_o !== 1'b1) begin
        @(negedge sys_clk_i);
        t++;
        if (t > 600) give_up();
      end
      @(negedge sys_clk_i);
    end
    wd_valid_i = 1'b0;
  endtask

  task automatic issue(input logic [5:0] b, input logic [10:0] a, input logic [1:0] c,
                       input logic [15:0] en, input logic sp, input logic rs);
    int t;
    t = 0;
    @(negedge sys_clk_i);
    req_bank_i = b;
    req_addr_i = a;
    req_qcode_i = c;
    req_en_i = en;
    req_split_i = sp;
    req_resume_i = rs;
    req_valid_i = 1'b1;
    while (req_taken_o !== 1'b1) begin
      @(negedge sys_clk_i);
      t++;
      if (t > 600) give_up();
    end
    req_valid_i = 1'b0;
    @(negedge sys_clk_i);
    `CSB_CHK(req_taken_o, 1'b0)
  endtask

  task automatic wr(input logic [5:0] b, input logic [10:0] a, input logic [1:0] c,
                    input logic [15:0] en, input logic rs);
    logic [127:0] w;
    int q;
    if (wq.size() < 4) fill(4);
    for (int k = 0; k < 4; k++) begin
      w = wq.pop_front();
      q = qord(c, k);
      for (int j = 0; j < 4; j++) begin
        if (en[4 * q + j]) mdl[key(b, a, q)][32 * j +: 32] = w[32 * j +: 32];
      end
    end
    issue(b, a, c, en, 1'b0, rs);
  endtask

  task automatic rd(input logic [5:0] b, input logic [10:0] a, input logic [1:0] c,
                    input logic sp);
    int cnt;
    cnt = (c == 2'b01) ? 3 : ((c == 2'b10) ? 2 : 4);
    for (int k = 0; k < cnt; k++) begin
      exp_q.push_back(mdl[key(b, a, qord(c, k))]);
      ep_q.push_back(4'h0);
    end
    issue(b, a, c, 16'h0000, sp, 1'b0);
  endtask

  task automatic drain();
    int t;
    t = 0;
    while (exp_q.size() != 0) begin
      @(negedge sys_clk_i);
      t++;
      if (t > 600) give_up();
    end
  endtask

  always @(negedge sys_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rd_data_o, 128'h0);
      end else begin
        mon_exp = exp_q.pop_front();
        mon_par = ep_q.pop_front();
        `CSB_CHK(rd_data_o, mon_exp)
        `CSB_CHK(rd_par_err_o, mon_par)
      end
    end
  end

  initial begin
    void'($urandom(32'h3994764c));
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    wr(6'h00, 11'h155, 2'b00, 16'hffff, 1'b0);
    wr(6'h01, 11'h7ff, 2'b11, 16'hffff, 1'b0);
    for (int c = 0; c < 4; c++) rd(6'h00, 11'h155, 2'(c), 1'b0);
    rd(6'h01, 11'h7ff, 2'b00, 1'b0);
    drain();
    $display("test order codes done");
    for (int b = 0; b < 4; b++) begin
      wr(6'(b), 11'h2aa, 2'b00, 16'hffff, 1'b0);
      wr(6'(b), 11'h2aa, 2'b11, 16'($urandom) | 16'h0001, 1'b0);
      issue(6'(b + 4), 11'h2aa, 2'b00, 16'h0000, 1'b0, 1'b0);
      issue(6'(b + 32), 11'h2aa, 2'b11, 16'h0000, 1'b0, 1'b0);
      rd(6'(b), 11'h2aa, 2'b00, 1'b0);
    end
    drain();
    $display("test enables done");
    fill(8);
    `CSB_CHK(wd_ready_o, 1'b0)
    wr(6'h02, 11'h001, 2'b00, 16'hffff, 1'b0);
    wr(6'h03, 11'h001, 2'b11, 16'hffff, 1'b0);
    rd(6'h02, 11'h001, 2'b11, 1'b0);
    rd(6'h03, 11'h001, 2'b00, 1'b0);
    drain();
    `CSB_CHK(wd_ready_o, 1'b1)
    $display("test buffer done");
    rd(6'h03, 11'h2aa, 2'b00, 1'b1);
    drain();
    clr_dr_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    clr_dr_i = 1'b0;
    for (int q = 0; q < 4; q++) mdl[key(6'h03, 11'h2aa, q)] = 128'h0;
    wr(6'h03, 11'h2aa, 2'b00, 16'h00ff, 1'b1);
    rd(6'h03, 11'h2aa, 2'b00, 1'b0);
    // Cleared half-words come back with even parity
    ep_q[2] = 4'hf;
    ep_q[3] = 4'hf;
    drain();
    $display("test split done");
    rd(6'h00, 11'h155, 2'b00, 1'b1);
    drain();
    mclr_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    mclr_i = 1'b0;
    rd(6'h00, 11'h155, 2'b11, 1'b0);
    drain();
    $display("test clear done");
    test_done();
  end
endmodule
